//--- core/rvr_bank.sv
// module: regulator voltage and enable register bank, top level
// Contract
// R01: converter codes 0x14-0x17 give 0.70-0.73 V
// R02: converter codes 0x18-0x9D in 5 mV steps
// R03: converter codes 0x9E-0xFF in 20 mV steps
// R04: converter codes below 0x14 are reserved
// R05: converter codes reset 0x6B and 0x59
// R06: linear code 0.8 V plus 100 mV
// R07: linear level resets 0x19, upper bits zero
// R08: on bit enables linear regulator, resets one
// R09: gating clear means enable bit only
// R10: gating set means enable bit and pin
// R11: discharge only while regulator is disabled
// R12: control bits 7:3 reserved, stored, reset zero
// R13: write reaches analog controls next clock
`timescale 1ns/10ps
`default_nettype none
module rvr_bank
    import rvr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    output logic             o_hit,
    input  wire logic        i_en_pin,
    output logic      [7:0]  o_converter_a_level,
    output logic      [7:0]  o_converter_b_level,
    output logic      [11:0] o_converter_a_mv,
    output logic      [11:0] o_converter_b_mv,
    output logic             o_converter_a_bad,
    output logic             o_converter_b_bad,
    output logic      [4:0]  o_linreg_a_level,
    output logic      [4:0]  o_linreg_b_level,
    output logic      [11:0] o_linreg_a_mv,
    output logic      [11:0] o_linreg_b_mv,
    output logic             o_linreg_a_bad,
    output logic             o_linreg_b_bad,
    output logic             o_linreg_a_run,
    output logic             o_linreg_b_run,
    output logic             o_linreg_a_discharge,
    output logic             o_linreg_b_discharge
);
    typedef struct packed {
        logic [7:0] conv_a;
        logic [7:0] conv_b;
        logic [7:0] lin_a_ct;
        logic [7:0] lin_b_ct;
        logic [7:0] lin_a_lv;
        logic [7:0] lin_b_lv;
        logic [1:0] pin_sync;
    } rvr_state_t;

    rvr_state_t s_q;
    rvr_state_t s_d;

    // pin is asynchronous to the logic clock
    always_comb begin
        s_d          = s_q;
        s_d.pin_sync = {s_q.pin_sync[0], i_en_pin};
        if (i_wr) begin
            unique case (i_addr)
                RVR_OFS_CONV_A:   s_d.conv_a   = i_wdata; // R05
                RVR_OFS_CONV_B:   s_d.conv_b   = i_wdata; // R05
                RVR_OFS_LIN_A_CT: s_d.lin_a_ct = i_wdata; // R12
                RVR_OFS_LIN_B_CT: s_d.lin_b_ct = i_wdata; // R12
                RVR_OFS_LIN_A_LV: s_d.lin_a_lv = i_wdata; // R06
                RVR_OFS_LIN_B_LV: s_d.lin_b_lv = i_wdata; // R06
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q.conv_a   <= RVR_RST_CONV_A; // R05
            s_q.conv_b   <= RVR_RST_CONV_B; // R05
            s_q.lin_a_ct <= RVR_RST_LIN_CT; // R08 R12
            s_q.lin_b_ct <= RVR_RST_LIN_CT;
            s_q.lin_a_lv <= RVR_RST_LIN_LV; // R07
            s_q.lin_b_lv <= RVR_RST_LIN_LV;
            s_q.pin_sync <= 2'h0;
        end else begin
            s_q <= s_d; // R13
        end
    end

    always_comb begin
        o_hit   = 1'b1;
        o_rdata = 8'h00;
        unique case (i_addr)
            RVR_OFS_CONV_A:   o_rdata = s_q.conv_a;
            RVR_OFS_CONV_B:   o_rdata = s_q.conv_b;
            RVR_OFS_LIN_A_CT: o_rdata = s_q.lin_a_ct;
            RVR_OFS_LIN_B_CT: o_rdata = s_q.lin_b_ct;
            RVR_OFS_LIN_A_LV: o_rdata = s_q.lin_a_lv;
            RVR_OFS_LIN_B_LV: o_rdata = s_q.lin_b_lv;
            default:          o_hit   = 1'b0;
        endcase
    end

    assign o_converter_a_level = s_q.conv_a; // R13
    assign o_converter_b_level = s_q.conv_b;
    assign o_linreg_a_level    = s_q.lin_a_lv[4:0];
    assign o_linreg_b_level    = s_q.lin_b_lv[4:0];

    rvr_conv_dec u_conv_a (
        .i_code (s_q.conv_a),
        .o_mv   (o_converter_a_mv),
        .o_bad  (o_converter_a_bad)
    );
    rvr_conv_dec u_conv_b (
        .i_code (s_q.conv_b),
        .o_mv   (o_converter_b_mv),
        .o_bad  (o_converter_b_bad)
    );

    rvr_lin_if lin_a ();
    rvr_lin_if lin_b ();
    assign lin_a.level  = s_q.lin_a_lv[4:0];
    assign lin_a.ctrl   = s_q.lin_a_ct[2:0];
    assign lin_a.pin_en = s_q.pin_sync[1];
    assign lin_b.level  = s_q.lin_b_lv[4:0];
    assign lin_b.ctrl   = s_q.lin_b_ct[2:0];
    assign lin_b.pin_en = s_q.pin_sync[1];

    rvr_lin_dec u_lin_a (.lin (lin_a));
    rvr_lin_dec u_lin_b (.lin (lin_b));

    assign o_linreg_a_run       = lin_a.run;
    assign o_linreg_b_run       = lin_b.run;
    assign o_linreg_a_discharge = lin_a.discharge;
    assign o_linreg_b_discharge = lin_b.discharge;
    assign o_linreg_a_bad       = lin_a.level_bad;
    assign o_linreg_b_bad       = lin_b.level_bad;
    assign o_linreg_a_mv        = lin_a.mv;
    assign o_linreg_b_mv        = lin_b.mv;
endmodule : rvr_bank
`default_nettype wire

//--- core/rvr_conv_dec.sv
// module: piecewise decode of a converter voltage code into millivolts
`timescale 1ns/10ps
`default_nettype none
module rvr_conv_dec
    import rvr_pkg::*;
(
    input  wire logic [7:0]  i_code,
    output logic      [11:0] o_mv,
    output logic             o_bad
);
    logic [11:0] off;
    always_comb begin
        o_bad = 1'b0;
        off   = 12'h000;
        o_mv  = 12'h000;
        if (i_code < RVR_CONV_BAND1_LO) begin
            o_bad = 1'b1; // R04
        end else if (i_code < RVR_CONV_BAND2_LO) begin
            off  = 12'(i_code - RVR_CONV_BAND1_LO);
            o_mv = RVR_CONV_BAND1_MV + 12'(off * RVR_CONV_STEP1_MV); // R01
        end else if (i_code < RVR_CONV_BAND3_LO) begin
            off  = 12'(i_code - RVR_CONV_BAND2_LO);
            o_mv = RVR_CONV_BAND2_MV + 12'(off * RVR_CONV_STEP2_MV); // R02
        end else begin
            off  = 12'(i_code - RVR_CONV_BAND3_LO);
            o_mv = RVR_CONV_BAND3_MV + 12'(off * RVR_CONV_STEP3_MV); // R03
        end
    end
endmodule : rvr_conv_dec
`default_nettype wire

//--- core/rvr_lin_dec.sv
// module: linear regulator on/off, discharge and level decode
`timescale 1ns/10ps
`default_nettype none
module rvr_lin_dec
    import rvr_pkg::*;
(
    rvr_lin_if.dec lin
);
    logic [11:0] step_mv;
    always_comb begin
        // R09 R10: pin only matters when gating is selected
        lin.run       = lin.ctrl[RVR_BIT_ON] & (~lin.ctrl[RVR_BIT_PIN_GATE] | lin.pin_en); // R08 R09 R10
        lin.discharge = lin.ctrl[RVR_BIT_DISCHARGE] & ~lin.run; // R11
        lin.level_bad = lin.level > RVR_LIN_CODE_MAX; // R06
        step_mv       = 12'(lin.level) * RVR_LIN_STEP_MV;
        lin.mv        = RVR_LIN_BASE_MV + step_mv; // R06
    end
endmodule : rvr_lin_dec
`default_nettype wire

//--- core/rvr_lin_if.sv
// interface: one linear regulator's control fields between bank and its decoder
`timescale 1ns/10ps
`default_nettype none
interface rvr_lin_if;
    logic [4:0]  level;
    logic [2:0]  ctrl;
    logic        pin_en;
    logic        run;
    logic        discharge;
    logic        level_bad;
    logic [11:0] mv;
    modport bank (output level, output ctrl, output pin_en, input run, input discharge, input level_bad, input mv);
    modport dec  (input level, input ctrl, input pin_en, output run, output discharge, output level_bad, output mv);
endinterface : rvr_lin_if
`default_nettype wire

//--- core/rvr_pkg.sv
// package: register map, reset values and code ranges for the regulator register bank
`default_nettype none
package rvr_pkg;
    localparam logic [7:0] RVR_OFS_CONV_A   = 8'h06;
    localparam logic [7:0] RVR_OFS_CONV_B   = 8'h07;
    localparam logic [7:0] RVR_OFS_LIN_A_CT = 8'h08;
    localparam logic [7:0] RVR_OFS_LIN_B_CT = 8'h09;
    localparam logic [7:0] RVR_OFS_LIN_A_LV = 8'h0A;
    localparam logic [7:0] RVR_OFS_LIN_B_LV = 8'h0B;

    localparam logic [7:0] RVR_RST_CONV_A   = 8'h6B;
    localparam logic [7:0] RVR_RST_CONV_B   = 8'h59;
    localparam logic [7:0] RVR_RST_LIN_CT   = 8'h07;
    localparam logic [7:0] RVR_RST_LIN_LV   = 8'h19;

    localparam int RVR_BIT_ON        = 0;
    localparam int RVR_BIT_PIN_GATE  = 1;
    localparam int RVR_BIT_DISCHARGE = 2;

    // converter and linear regulator code bands, millivolts
    localparam logic [7:0]  RVR_CONV_BAND1_LO = 8'h14;
    localparam logic [7:0]  RVR_CONV_BAND2_LO = 8'h18;
    localparam logic [7:0]  RVR_CONV_BAND3_LO = 8'h9E;
    localparam logic [11:0] RVR_CONV_BAND1_MV = 12'h2BC;
    localparam logic [11:0] RVR_CONV_BAND2_MV = 12'h2DF;
    localparam logic [11:0] RVR_CONV_BAND3_MV = 12'h58C;
    localparam logic [11:0] RVR_CONV_STEP1_MV = 12'h00A;
    localparam logic [11:0] RVR_CONV_STEP2_MV = 12'h005;
    localparam logic [11:0] RVR_CONV_STEP3_MV = 12'h014;
    localparam logic [4:0]  RVR_LIN_CODE_MAX  = 5'h19;
    localparam logic [11:0] RVR_LIN_BASE_MV   = 12'h320;
    localparam logic [11:0] RVR_LIN_STEP_MV   = 12'h064;
endpackage : rvr_pkg
`default_nettype wire

//--- test/rvr_bank_asserts.sv
// checker: timing and decode properties of the regulator register bank
`timescale 1ns/10ps
`default_nettype none
module rvr_bank_asserts (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_wr,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic [7:0]  o_converter_a_level,
    input wire logic [11:0] o_converter_a_mv,
    input wire logic        o_converter_a_bad,
    input wire logic [4:0]  o_linreg_a_level,
    input wire logic [11:0] o_linreg_a_mv,
    input wire logic        o_linreg_a_bad,
    input wire logic        o_linreg_a_run,
    input wire logic        o_linreg_a_discharge
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_cbad; o_converter_a_bad == (o_converter_a_level < 8'h14); endproperty
    a_cbad: assert property (p_cbad) else $error("converter flag wrong");
    property p_b1; o_converter_a_level inside {[8'h14:8'h17]} |-> o_converter_a_mv == 700 + 10 * (o_converter_a_level - 8'h14); endproperty
    a_b1: assert property (p_b1) else $error("low band level wrong");
    property p_b2; o_converter_a_level inside {[8'h18:8'h9D]} |-> o_converter_a_mv == 735 + 5 * (o_converter_a_level - 8'h18); endproperty
    a_b2: assert property (p_b2) else $error("mid band level wrong");
    property p_b3; o_converter_a_level >= 8'h9E |-> o_converter_a_mv == 1420 + 20 * (o_converter_a_level - 8'h9E); endproperty
    a_b3: assert property (p_b3) else $error("high band level wrong");
    property p_lmv; !o_linreg_a_bad |-> o_linreg_a_mv == 800 + 100 * o_linreg_a_level; endproperty
    a_lmv: assert property (p_lmv) else $error("linear level wrong");
    property p_lbad; o_linreg_a_bad == (o_linreg_a_level > 5'h19); endproperty
    a_lbad: assert property (p_lbad) else $error("linear flag wrong");
    property p_wr; i_wr && i_addr == 8'h06 |=> o_converter_a_level == $past(i_wdata); endproperty
    a_wr: assert property (p_wr) else $error("write not forwarded");
    property p_off; i_wr && i_addr == 8'h08 && !i_wdata[0] |=> !o_linreg_a_run && o_linreg_a_discharge == $past(i_wdata[2]); endproperty
    a_off: assert property (p_off) else $error("off or discharge wrong");
    property p_ungate; i_wr && i_addr == 8'h08 && i_wdata[1:0] == 2'h1 |=> o_linreg_a_run; endproperty
    a_ungate: assert property (p_ungate) else $error("ungated run wrong");
    // first edge after release still shows the reset codes
    property p_rst; $fell(i_rst) |-> o_converter_a_level == 8'h6B && o_linreg_a_level == 5'h19; endproperty
    a_rst: assert property (p_rst) else $error("reset code wrong");
    cover property (i_wr && i_addr == 8'h08);
    cover property (o_linreg_a_discharge && !o_linreg_a_run);
    cover property (o_converter_a_bad);
endmodule : rvr_bank_asserts
bind rvr_bank rvr_bank_asserts rvr_bank_asserts_i (.*);
`default_nettype wire

//--- test/testbench.sv
// testbench: register accesses and output checks for the regulator register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_en_pin = 1'b0;
    logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_converter_a_level, o_converter_b_level;
    logic [11:0] o_converter_a_mv, o_converter_b_mv, o_linreg_a_mv, o_linreg_b_mv;
    logic [4:0]  o_linreg_a_level, o_linreg_b_level;
    logic        o_hit, o_converter_a_bad, o_converter_b_bad, o_linreg_a_bad, o_linreg_b_bad;
    logic        o_linreg_a_run, o_linreg_b_run, o_linreg_a_discharge, o_linreg_b_discharge;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    localparam logic [7:0]  CODE [8] = '{8'h00, 8'h13, 8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF};
    localparam logic [11:0] MV [8] = '{12'h000, 12'h000, 12'h2BC, 12'h2DA, 12'h2DF, 12'h578, 12'h58C, 12'hD20};
    localparam logic [7:0]  RST [6] = '{8'h6B, 8'h59, 8'h07, 8'h07, 8'h19, 8'h19};
    rvr_bank rvr_bank_i (.*);
    always #2 i_clk = ~i_clk;
    task automatic complete_run;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_wr = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_addr = a;
        #1 cmp(12'(o_rdata), 12'(exp));
    endtask : rd
    // hang guard, well above the roughly 70 cycles the sequence needs
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        for (int k = 0; k < 6; k++) rd(8'(6 + k), RST[k]);
        cmp(12'(o_linreg_a_run), 12'h000);
        cmp(12'(o_linreg_a_discharge), 12'h001);
        @(negedge i_clk);
        i_en_pin = 1'b1;
        // pin passes two sync flops first
        repeat (3) @(negedge i_clk);
        cmp(12'({o_linreg_a_run, o_linreg_b_run, o_linreg_a_discharge}), 12'h006);
        i_en_pin = 1'b0;
        repeat (3) @(negedge i_clk);
        wr(8'h08, 8'h01);
        cmp(12'(o_linreg_a_run), 12'h001);
        wr(8'h08, 8'h03);
        cmp(12'(o_linreg_a_run), 12'h000);
        wr(8'h08, 8'h04);
        cmp(12'({o_linreg_a_run, o_linreg_a_discharge}), 12'h001);
        wr(8'h08, 8'h00);
        cmp(12'(o_linreg_a_discharge), 12'h000);
        wr(8'h09, 8'hF9);
        rd(8'h09, 8'hF9);
        cmp(12'(o_linreg_b_run), 12'h001);
        wr(8'h0A, 8'h00);
        wr(8'h0B, 8'h19);
        cmp(o_linreg_a_mv, 12'h320);
        cmp(o_linreg_b_mv, 12'hCE4);
        cmp(12'({o_linreg_a_level, o_linreg_b_level}), 12'h019);
        wr(8'h0A, 8'h1A);
        cmp(12'({o_linreg_a_bad, o_linreg_b_bad}), 12'h002);
        foreach (CODE[k]) begin
            wr(8'h06, CODE[k]);
            wr(8'h07, CODE[k]);
            cmp(o_converter_a_mv, MV[k]);
            cmp(o_converter_b_mv, MV[k]);
            cmp(12'(o_converter_b_level), 12'(CODE[k]));
            cmp(12'({o_converter_a_bad, o_converter_b_bad}), (k < 2) ? 12'h003 : 12'h000);
        end
        wr(8'h20, 8'h55);
        rd(8'h20, 8'h00);
        cmp(12'(o_hit), 12'h000);
        rd(8'h06, 8'hFF);
        @(negedge i_clk);
        i_rst = 1'b1;
        @(negedge i_clk);
        i_rst = 1'b0;
        rd(8'h06, 8'h6B);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
